// File: rtl/ssf_status_flags.v
/*
  Status flag, error flag and ninth-bit logic of an asynchronous serial unit,
  with an APB slave for its registers and the data buffer.
  Assumes the shifter, framing and baud logic sit outside and give one-cycle
  event pulses synchronous to pclk.
*/
`include "ssf_defines.vh"

module ssf_status_flags (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_load,
  input  wire [7:0]  rx_data,
  input  wire        rx_bit8,
  input  wire        rx_noise,
  input  wire        rx_frame_err,
  input  wire        rx_parity_err,
  input  wire        rx_break,
  input  wire        rx_idle,
  input  wire        rx_ones_seen,
  input  wire        rx_start_seen,
  input  wire        rx_false_start,
  input  wire        rx_enable,
  input  wire        tx_xfer,
  input  wire        tx_busy,
  input  wire        tx_queue,
  output wire [7:0]  tx_data,
  output wire        tx_bit8,
  output wire        tx_buf_full,
  output wire        nine_bit_mode,
  output wire        unit_enable,
  output wire        tx_irq,
  output wire        rx_irq,
  output wire        err_irq
);

  // ***************************************************
  // apb decode
  // ***************************************************
  function [7:0] ssf_index;
    input [11:0] a;
    ssf_index = a[9:2];
  endfunction

  wire       acc    = psel & penable;
  wire [7:0] idx    = ssf_index(paddr);
  wire       hit_c3 = idx == `SSF_IDX_CTRL_THREE;
  wire       hit_s1 = idx == `SSF_IDX_STATUS_ONE;
  wire       hit_s2 = idx == `SSF_IDX_STATUS_TWO;
  wire       hit_db = idx == `SSF_IDX_DATA_BUF;
  wire       hit_cm = idx == `SSF_IDX_CTRL_MAIN;
  wire       mapped = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0) &
                      (hit_c3 | hit_s1 | hit_s2 | hit_db | hit_cm);
  // status snapshots follow the read data, which is captured in setup
  wire       rd_su  = psel & ~penable & ~pwrite & mapped;
  wire       rd_s1  = rd_su & hit_s1;
  wire       rd_s2  = rd_su & hit_s2;
  wire       rd_db  = acc & ~pwrite & mapped & hit_db;
  wire       wr_db  = acc & pwrite & mapped & hit_db;
  wire       wr_c3  = acc & pwrite & mapped & hit_c3;
  wire       wr_cm  = acc & pwrite & mapped & hit_cm;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ***************************************************
  // state
  // ***************************************************
  reg [7:0] s1_r;
  reg [7:0] s1_nxt;
  reg [7:0] snap1_r;
  reg       brk_r;
  reg       brk_nxt;
  reg       snap2_r;
  reg       brk_arm_r;
  reg       prog_r;
  reg       idle_arm_r;
  reg [5:0] c3_r;
  reg [7:0] cm_r;
  reg [7:0] rx_buf_r;
  reg [7:0] tx_buf_r;
  reg       rx_ninth_r;
  reg       tx_ninth_r;
  reg [7:0] rdata_r;

  wire nine    = cm_r[`SSF_CM_NINE_BIT];
  wire enable  = cm_r[`SSF_CM_ENABLE];
  wire cm_en_n = wr_cm & ~pwdata[`SSF_CM_ENABLE];

  // a data read clears exactly the receive flags latched by the last status
  // read; the transmit flags have their own set and clear paths
  wire [7:0] clr1 = rd_db ? {2'b00, snap1_r[5:0]} : 8'h00;
  wire       txe_clr = wr_db & snap1_r[`SSF_S1_TX_EMPTY];

  wire brk_evt  = rx_break & brk_arm_r;
  wire char_in  = rx_load | brk_evt;
  // a character that meets a full buffer not freed this cycle is dropped
  wire full_now = s1_r[`SSF_S1_RX_FULL] & ~clr1[`SSF_S1_RX_FULL];
  wire ovr_evt  = char_in & full_now;
  wire accept   = char_in & ~full_now;

  // ***************************************************
  // status one next state
  // ***************************************************
  always @* begin
    s1_nxt = s1_r & ~clr1;
    if (txe_clr) begin
      s1_nxt[`SSF_S1_TX_EMPTY] = 1'b0;
    end
    if (tx_xfer) begin
      s1_nxt[`SSF_S1_TX_EMPTY] = 1'b1;
    end
    // any newly queued data, preamble or break ends transmission complete
    if (tx_queue | wr_db) begin
      s1_nxt[`SSF_S1_TX_DONE] = 1'b0;
    end else if (s1_r[`SSF_S1_TX_EMPTY] & ~tx_busy) begin
      s1_nxt[`SSF_S1_TX_DONE] = 1'b1;
    end
    if (~enable | cm_en_n) begin
      s1_nxt[`SSF_S1_TX_EMPTY] = 1'b1;
      s1_nxt[`SSF_S1_TX_DONE]  = 1'b1;
    end
    if (accept) begin
      s1_nxt[`SSF_S1_RX_FULL] = 1'b1;
      if (rx_noise) begin
        s1_nxt[`SSF_S1_NOISE] = 1'b1;
      end
      if (rx_frame_err | brk_evt) begin
        s1_nxt[`SSF_S1_FRAMING] = 1'b1;
      end
      if (rx_parity_err) begin
        s1_nxt[`SSF_S1_PARITY] = 1'b1;
      end
    end
    if (ovr_evt) begin
      s1_nxt[`SSF_S1_OVERRUN] = 1'b1;
    end
    if (rx_idle & idle_arm_r) begin
      s1_nxt[`SSF_S1_IDLE] = 1'b1;
    end
  end

  // ***************************************************
  // status two next state
  // ***************************************************
  always @* begin
    brk_nxt = brk_r;
    if (rd_db & snap2_r) begin
      brk_nxt = 1'b0;
    end
    if (brk_evt) begin
      brk_nxt = 1'b1;
    end
  end

  // ***************************************************
  // flag registers
  // ***************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= `SSF_RST_STATUS_ONE;
      brk_r <= 1'b0;
    end else begin
      s1_r  <= s1_nxt;
      brk_r <= brk_nxt;
    end
  end

  // snapshots of the flags software has seen, used by the next data access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap1_r <= 8'h00;
      snap2_r <= 1'b0;
    end else begin
      if (rd_s1) begin
        snap1_r <= s1_r;
      end else if (rd_db | wr_db) begin
        snap1_r <= 8'h00;
      end
      if (rd_s2) begin
        snap2_r <= brk_r;
      end else if (rd_db) begin
        snap2_r <= 1'b0;
      end
    end
  end

  // a held break line must return high before another break counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_arm_r <= 1'b1;
    end else if (brk_evt) begin
      brk_arm_r <= 1'b0;
    end else if (rx_ones_seen) begin
      brk_arm_r <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_r <= 1'b0;
    end else if (rx_start_seen) begin
      prog_r <= 1'b1;
    end else if (rx_false_start | rx_idle) begin
      prog_r <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_arm_r <= 1'b0;
    end else if (~rx_enable | (clr1[`SSF_S1_IDLE] & ~s1_nxt[`SSF_S1_IDLE])) begin
      idle_arm_r <= 1'b0;
    end else if (accept) begin
      idle_arm_r <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c3_r <= 6'h00;
      cm_r <= `SSF_RST_CTRL;
    end else begin
      if (wr_c3) begin
        c3_r <= pwdata[5:0];
      end
      if (wr_cm) begin
        cm_r <= pwdata[7:0];
      end
    end
  end

  // ***************************************************
  // data buffers and ninth bits, untouched by reset
  // ***************************************************
  always @(posedge pclk) begin
    if (accept) begin
      rx_buf_r <= brk_evt ? 8'h00 : rx_data;
      // the buffer holds zero after a break, so the ninth field reads zero in both modes
      if (brk_evt) begin
        rx_ninth_r <= 1'b0;
      end else begin
        rx_ninth_r <= nine ? rx_bit8 : rx_data[7];
      end
    end
    if (wr_db) begin
      tx_buf_r <= pwdata[7:0];
    end
    if (wr_c3) begin
      tx_ninth_r <= pwdata[`SSF_C3_TX_NINTH];
    end
  end

  // ***************************************************
  // read data
  // ***************************************************
  reg [7:0] rmux;
  always @* begin
    rmux = 8'h00;
    if (hit_c3) begin
      rmux = {rx_ninth_r, tx_ninth_r, c3_r};
    end else if (hit_s1) begin
      rmux = s1_r;
    end else if (hit_s2) begin
      rmux = {6'h00, brk_r, prog_r};
    end else if (hit_db) begin
      rmux = rx_buf_r;
    end else if (hit_cm) begin
      rmux = cm_r;
    end
    if (!mapped) begin
      rmux = 8'h00;
    end
  end

  // registered on setup so data stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 8'h00;
    end else if (psel & ~penable & ~pwrite) begin
      rdata_r <= rmux;
    end
  end

  assign prdata = {24'h000000, rdata_r};

  // ***************************************************
  // outputs and interrupt requests
  // ***************************************************
  assign tx_data       = tx_buf_r;
  assign tx_bit8       = tx_ninth_r;
  assign tx_buf_full   = ~s1_r[`SSF_S1_TX_EMPTY];
  assign nine_bit_mode = nine;
  assign unit_enable   = enable;

  assign tx_irq = enable & ((s1_r[`SSF_S1_TX_EMPTY] & cm_r[`SSF_CM_TXE_IE]) |
                            (s1_r[`SSF_S1_TX_DONE] & cm_r[`SSF_CM_TXD_IE]));
  assign rx_irq = (s1_r[`SSF_S1_RX_FULL] & cm_r[`SSF_CM_RXF_IE]) |
                  (s1_r[`SSF_S1_IDLE] & cm_r[`SSF_CM_IDLE_IE]);
  // break and in-progress flags never request; error flags sit in the same
  // bit positions as their enables, so one gate per bit
  wire [3:0] err_req;
  genvar     g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_err
      assign err_req[g] = s1_r[g] & c3_r[g];
    end
  endgenerate
  assign err_irq = |err_req;

endmodule

// File: pkg/ssf_defines.vh
/*
  Register indices, address width, field positions and reset values of the
  serial status and error flag block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SSF_DEFINES_VH
`define SSF_DEFINES_VH

// ***************************************************
// register indices, byte address is four times index
// ***************************************************
`define SSF_IDX_CTRL_THREE 8'h15
`define SSF_IDX_STATUS_ONE 8'h16
`define SSF_IDX_STATUS_TWO 8'h17
`define SSF_IDX_DATA_BUF   8'h18
`define SSF_IDX_CTRL_MAIN  8'h19
`define SSF_ADDR_W         12

// ***************************************************
// control three fields
// ***************************************************
`define SSF_C3_RX_NINTH  7
`define SSF_C3_TX_NINTH  6
`define SSF_C3_DMA_RX    5
`define SSF_C3_DMA_TX    4
`define SSF_C3_OVR_IE    3
`define SSF_C3_NOISE_IE  2
`define SSF_C3_FRAME_IE  1
`define SSF_C3_PAR_IE    0

// ***************************************************
// status one and two fields
// ***************************************************
`define SSF_S1_TX_EMPTY  7
`define SSF_S1_TX_DONE   6
`define SSF_S1_RX_FULL   5
`define SSF_S1_IDLE      4
`define SSF_S1_OVERRUN   3
`define SSF_S1_NOISE     2
`define SSF_S1_FRAMING   1
`define SSF_S1_PARITY    0
`define SSF_S2_BREAK     1
`define SSF_S2_RX_PROG   0

// ***************************************************
// main control fields
// ***************************************************
`define SSF_CM_TXE_IE    7
`define SSF_CM_TXD_IE    6
`define SSF_CM_RXF_IE    5
`define SSF_CM_IDLE_IE   4
`define SSF_CM_ENABLE    1
`define SSF_CM_NINE_BIT  0

// ***************************************************
// reset values
// ***************************************************
`define SSF_RST_STATUS_ONE 8'hc0
`define SSF_RST_CTRL       8'h00

`endif

// File: tb/ssf_tx_partner.sv
/* transmit shifter model for the status flag block
   assumes pclk and presetn shared with the block */
module ssf_tx_partner (
  input  logic       pclk,
  input  logic       presetn,
  input  logic       tx_buf_full,
  input  logic [7:0] tx_data,
  input  logic       tx_bit8,
  input  logic       slow,
  output logic       tx_xfer,
  output logic       tx_busy,
  output logic [8:0] got,
  output int         n_got
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ****
  // shifter takes the buffer only once free
  // ****
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_xfer <= 1'b0;
      tx_busy <= 1'b0;
      cnt <= 0;
      n_got <= 0;
    end else begin
      tx_xfer <= 1'b0;
      tx_busy <= (cnt > 1);
      if (cnt != 0)
        cnt <= cnt - 1;
      if (cnt == 0 && tx_buf_full && !tx_xfer) begin
        tx_xfer <= 1'b1;
        tx_busy <= 1'b1;
        cnt <= slow ? 12 : 3;
        got <= {tx_bit8, tx_data};
        n_got <= n_got + 1;
      end
    end
  end
endmodule

// File: tb/ssf_status_flags_asserts.sv
/* port checker for the status flag block
   assumes enables are shadowed from apb writes */
module ssf_status_flags_asserts (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic        pslverr,
  input logic        rx_load,
  input logic        rx_noise,
  input logic        rx_frame_err,
  input logic        rx_parity_err,
  input logic        rx_break,
  input logic        rx_ones_seen,
  input logic        tx_xfer,
  input logic        tx_buf_full,
  input logic        unit_enable,
  input logic        tx_irq,
  input logic        rx_irq,
  input logic        err_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cm_r;
  logic [7:0] c3_r;
  logic       arm_r;
  wire        wr = psel && penable && pwrite;
  // ****
  // shadow of the enable registers
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_r <= 8'h00;
      c3_r <= 8'h00;
      arm_r <= 1'b1;
    end else begin
      if (wr && paddr == 12'h064)
        cm_r <= pwdata[7:0];
      if (wr && paddr == 12'h054)
        c3_r <= pwdata[7:0];
      // a break only counts once the line has shown ones again
      if (rx_break && arm_r)
        arm_r <= 1'b0;
      else if (rx_ones_seen)
        arm_r <= 1'b1;
    end
  end
  a_slverr_map: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h054, 12'h058, 12'h05c, 12'h060, 12'h064})) else $error("bad slave error");
  a_err_masked: assert property (c3_r[3:0] == 4'h0 |-> !err_irq) else $error("masked err irq");
  a_frame_irq: assert property (rx_load && rx_frame_err && c3_r[1] |=> err_irq) else $error("no frame irq");
  a_parity_irq: assert property (rx_load && rx_parity_err && c3_r[0] |=> err_irq) else $error("no par irq");
  a_noise_irq: assert property (rx_load && rx_noise && c3_r[2] |=> err_irq) else $error("no noise irq");
  a_break_irq: assert property (rx_break && arm_r |=> (err_irq || !c3_r[1]) && (rx_irq || !cm_r[5]))
    else $error("break flags");
  a_rx_full_irq: assert property (rx_load && cm_r[5] |=> rx_irq) else $error("no rx irq");
  a_rx_masked: assert property (cm_r[5:4] == 2'b00 |-> !rx_irq) else $error("masked rx irq");
  a_tx_empty_set: assert property (tx_xfer |=> !tx_buf_full) else $error("tx empty not set");
  a_tx_masked: assert property (cm_r[7:6] == 2'b00 |-> !tx_irq) else $error("masked tx irq");
  a_unit_off: assert property (!unit_enable && !$past(unit_enable) |-> !tx_buf_full && !tx_irq)
    else $error("unit off tx flags");
endmodule
bind ssf_status_flags ssf_status_flags_asserts i_chk (.*);

// File: tb/ssf_status_flags_bench.sv
/* self-checking bench of the status flag block
   assumes the tx partner and the bound checker */
`include "ssf_defines.vh"
module ssf_status_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] ad_c3 = `SSF_IDX_CTRL_THREE * 4;
  localparam logic [11:0] ad_s1 = `SSF_IDX_STATUS_ONE * 4;
  localparam logic [11:0] ad_s2 = `SSF_IDX_STATUS_TWO * 4;
  localparam logic [11:0] ad_db = `SSF_IDX_DATA_BUF * 4;
  localparam logic [11:0] ad_cm = `SSF_IDX_CTRL_MAIN * 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, e, b8;
  logic rx_load = 0, rx_bit8 = 0, rx_noise = 0, rx_frame_err = 0, rx_parity_err = 0, rx_break = 0;
  logic rx_enable = 1, tx_queue = 0, pready, pslverr, tx_xfer, tx_busy, tx_bit8, tx_buf_full;
  logic nine_bit_mode, unit_enable, tx_irq, rx_irq, err_irq;
  logic [3:0] ev = 0;
  wire rx_idle = ev[0], rx_ones_seen = ev[1], rx_start_seen = ev[2], rx_false_start = ev[3];
  logic [7:0] rx_data = 0, tx_data, d;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, seed = 32'h0c8862c1;
  logic [8:0] got;
  int n_got, bad_count = 0, num_checks = 0, cyc = 0;
  ssf_status_flags i_dut (.*);
  ssf_tx_partner i_tx (.*);
  initial forever #2 pclk = ~pclk;
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rx(input logic [7:0] dd, input logic b, input logic [2:0] er, input logic brk);
    rx_load <= !brk;
    rx_break <= brk;
    rx_data <= dd;
    rx_bit8 <= b;
    {rx_noise, rx_frame_err, rx_parity_err} <= er;
    @(posedge pclk);
    rx_load <= 1'b0;
    rx_break <= 1'b0;
    {rx_noise, rx_frame_err, rx_parity_err} <= 3'b000;
  endtask
  task automatic ev_p(input logic [3:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 4'h0;
  endtask
  task automatic clr;
    rd(ad_s1);
    rd(ad_s2);
    rd(ad_db);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ad_s1);
    chk(q, 32'hc0);
    rd(ad_s2);
    chk(q, 32'h0);
    rd(ad_c3);
    chk(q & 32'h3f, 32'h0);
    rd(12'h070);
    chk(e, 1'b1);
    wr(ad_c3, 32'h4f);
    for (int i = 0; i < 8; i++) begin
      {b8, d} = 9'($random(seed));
      wr(ad_cm, 32'h22 | i[0]);
      rx(d, b8, 3'b000, 1'b0);
      rd(ad_s1);
      chk(q[5], 1'b1);
      chk(rx_irq, 1'b1);
      chk(nine_bit_mode, i[0]);
      rd(ad_c3);
      chk(q[7], i[0] ? b8 : d[7]);
      rd(ad_db);
      chk(q, d);
      rd(ad_s1);
      chk(q[5], 1'b0);
    end
    rx(8'h11, 1'b0, 3'b000, 1'b0);
    rd(ad_s1);
    rx(8'h22, 1'b0, 3'b000, 1'b0);
    rd(ad_db);
    chk(q, 32'h11);
    rd(ad_s1);
    chk(q[5:3], 3'b001);
    chk(err_irq, 1'b1);
    rd(ad_db);
    chk(err_irq, 1'b0);
    for (int k = 0; k < 3; k++) begin
      rx(8'h5a, 1'b0, 3'b001 << k, 1'b0);
      rd(ad_s1);
      chk(q[2:0], 3'b001 << k);
      chk(err_irq, 1'b1);
      rd(ad_db);
      chk(err_irq, 1'b0);
    end
    rx(8'h00, 1'b1, 3'b000, 1'b1);
    rd(ad_c3);
    chk(q[7], 1'b0);
    rd(ad_s1);
    chk(q[5] & q[1], 1'b1);
    rd(ad_s2);
    chk(q[1], 1'b1);
    rd(ad_db);
    rd(ad_s2);
    chk(q[1], 1'b0);
    rx(8'h00, 1'b0, 3'b000, 1'b1);
    rd(ad_s2);
    chk(q[1], 1'b0);
    clr();
    ev_p(4'b0010);
    rx(8'h00, 1'b0, 3'b000, 1'b1);
    rd(ad_s2);
    chk(q[1], 1'b1);
    clr();
    rx(8'h33, 1'b0, 3'b000, 1'b0);
    clr();
    ev_p(4'b0100);
    rd(ad_s2);
    chk(q[0], 1'b1);
    ev_p(4'b1000);
    rd(ad_s2);
    chk(q[0], 1'b0);
    ev_p(4'b0100);
    @(posedge pclk);
    ev_p(4'b0001);
    rd(ad_s2);
    chk(q[0], 1'b0);
    rd(ad_s1);
    chk(q[4], 1'b1);
    rd(ad_db);
    ev_p(4'b0001);
    rd(ad_s1);
    chk(q[4], 1'b0);
    rx(8'h44, 1'b0, 3'b000, 1'b0);
    clr();
    rx_enable <= 1'b0;
    @(posedge pclk);
    rx_enable <= 1'b1;
    ev_p(4'b0001);
    rd(ad_s1);
    chk(q[4], 1'b0);
    rd(ad_s2);
    chk(q[0], 1'b0);
    wr(ad_cm, 32'h81);
    chk(tx_irq, 1'b0);
    wr(ad_cm, 32'h83);
    chk(tx_irq, 1'b1);
    for (int j = 0; j < 4; j++) begin
      d = 8'($random(seed));
      slow <= j[0];
      rd(ad_s1);
      chk(q[7:6], 2'b11);
      wr(ad_db, d);
      for (int n = 0; n < 40 && n_got != j + 1; n++) @(posedge pclk);
      @(posedge pclk);
      chk(got, {1'b1, d});
      if (j[0]) begin
        rd(ad_s1);
        chk(q[7:6], 2'b10);
      end
      for (int n = 0; n < 40 && tx_busy !== 1'b0; n++) @(posedge pclk);
      @(posedge pclk);
    end
    tx_queue <= 1'b1;
    @(posedge pclk);
    rd(ad_s1);
    chk(q[6], 1'b0);
    tx_queue <= 1'b0;
    @(posedge pclk);
    rd(ad_s1);
    chk(q[6], 1'b1);
    stop_test();
  end
endmodule
